/* hw/vit_edge_det.sv */
// synchronised per-pin edge detector with polarity and enable masks
`timescale 1ns/1ps
module vit_edge_det
    import vit_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // pins and configuration
    input  wire logic [W-1:0] pinIn,
    input  wire logic [W-1:0] riseSel,
    input  wire logic [W-1:0] pinEn,
    // result
    output      logic         anyHit
);
    logic [W-1:0] sync1_reg;
    logic [W-1:0] sync2_reg;
    logic [W-1:0] prev_reg;
    logic [W-1:0] hit;

    // 1 selects rising edge, 0 falling edge
    always_comb begin
        for (int i = 0; i < W; i++) begin
            hit[i] = pinEn[i] & (riseSel[i] ? (sync2_reg[i] & ~prev_reg[i])
                                            : (~sync2_reg[i] & prev_reg[i]));
        end
        anyHit = |hit;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= pinIn;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end
endmodule // vit_edge_det

/* hw/vit_irq_ctrl.sv */
// vectored interrupt controller with free-running microsecond timer
// Operation
// - eight maskable sources, each with own vector
// - sources: bus reset, taps, endpoints, ports
// - timer taps interrupt on rising toggle only
// - endpoint interrupts after any packet transfer
// - per-pin enable mask on sink port
// - per-pin enable mask on general ports
// - sink port edge selectable per pin
// - general port edge selected per port
// - polarity picks rising or falling edge
// - all general pins share one vector
// - sink port has its own vector
// - 12-bit up-counter at 1 MHz ticks
// - low byte read latches top nibble
// - top nibble read returns latched copy
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module vit_irq_ctrl
    import vit_pkg::*;
#(
    parameter int SINK_W  = 8,
    parameter int GP_PORTS = 4,
    parameter int GP_W    = 8
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    // register port
    input  wire logic [ADDR_W-1:0]       regAddr,
    input  wire logic [DATA_W-1:0]       regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output      logic [DATA_W-1:0]       regRdData,
    // usb engine events, same clock
    input  wire logic                    usbBusReset,
    input  wire logic [2:0]              epDone,
    // port pins, asynchronous
    input  wire logic [SINK_W-1:0]       sinkPin,
    input  wire logic [GP_PORTS*GP_W-1:0] gpPin,
    // processor side
    input  wire logic                    intAck,
    output      logic                    irq,
    output      logic [2:0]              irqVector
);
    // tick divider
    logic [7:0]              tickCnt_reg;
    logic [7:0]              tickCnt_next;
    logic                    tick_reg;
    logic                    tick_next;

    // timer and nibble latch
    logic [TIMER_W-1:0]      timer_reg;
    logic [TIMER_W-1:0]      timer_next;
    logic [3:0]              hiHold_reg;
    logic [3:0]              hiHold_next;
    logic                    tap128;
    logic                    tap1ms;

    // configuration
    logic [NUM_SRC-1:0]      intMask_reg;
    logic [NUM_SRC-1:0]      intMask_next;
    logic [SINK_W-1:0]       sinkIen_reg;
    logic [SINK_W-1:0]       sinkIen_next;
    logic [SINK_W-1:0]       sinkPol_reg;
    logic [SINK_W-1:0]       sinkPol_next;
    logic [GP_PORTS*GP_W-1:0] gpIen_reg;
    logic [GP_PORTS*GP_W-1:0] gpIen_next;
    logic [GP_PORTS-1:0]     gpPol_reg;
    logic [GP_PORTS-1:0]     gpPol_next;
    logic [GP_PORTS*GP_W-1:0] gpPolPin;

    // status and presentation
    logic [NUM_SRC-1:0]      status_reg;
    logic [NUM_SRC-1:0]      status_next;
    logic [NUM_SRC-1:0]      srcEvent;
    logic [NUM_SRC-1:0]      clrBits;
    logic [NUM_SRC-1:0]      active;
    logic                    pickValid;
    logic [2:0]              pickIdx;
    logic                    irq_reg;
    logic                    irq_next;
    logic [2:0]              vec_reg;
    logic [2:0]              vec_next;

    // read data
    logic [DATA_W-1:0]       rdData_reg;
    logic [DATA_W-1:0]       rdData_next;

    // port edge events
    logic                    sinkHit;
    logic                    gpHit;

    function automatic logic isAddr(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // ---------------------------------------------------------------
    // microsecond tick: one enable pulse every TICK_CYCLES clocks
    always_comb begin
        tick_next    = 1'b0;
        tickCnt_next = tickCnt_reg + 8'h01;
        if (tickCnt_reg == TICK_LAST) begin
            tickCnt_next = 8'h00;
            tick_next    = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tickCnt_reg <= 8'h00;
            tick_reg    <= 1'b0;
        end else begin
            tickCnt_reg <= tickCnt_next;
            tick_reg    <= tick_next;
        end
    end

    // ---------------------------------------------------------------
    // free-running timer; wraps silently, firmware differences stay valid
    always_comb begin
        timer_next  = timer_reg;
        hiHold_next = hiHold_reg;
        if (tick_reg) begin
            timer_next = timer_reg + 12'h001;
        end
        // latch uses the value the low-byte read returns, so both halves agree
        if (regRd && isAddr(regAddr, OFS_TMR_LO)) begin
            hiHold_next = timer_reg[TIMER_W-1:8];
        end
    end

    // taps fire only when the bit goes 0 to 1 on this tick
    assign tap128 = tick_reg & ~timer_reg[TAP_128US_BIT] & timer_next[TAP_128US_BIT];
    assign tap1ms = tick_reg & ~timer_reg[TAP_1MS_BIT] & timer_next[TAP_1MS_BIT];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_reg  <= RST_TIMER;
            hiHold_reg <= 4'h0;
        end else begin
            timer_reg  <= timer_next;
            hiHold_reg <= hiHold_next;
        end
    end

    // ---------------------------------------------------------------
    // port edge detection
    vit_edge_det #(
        .W (SINK_W)
    ) u_sink_edge (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pinIn   (sinkPin),
        .riseSel (sinkPol_reg),
        .pinEn   (sinkIen_reg),
        .anyHit  (sinkHit)
    );

    // one polarity bit per port fans out to all its pins
    genvar gp;
    generate
        for (gp = 0; gp < GP_PORTS; gp++) begin : g_gp_pol
            assign gpPolPin[gp*GP_W +: GP_W] = {GP_W{gpPol_reg[gp]}};
        end
    endgenerate

    vit_edge_det #(
        .W (GP_PORTS*GP_W)
    ) u_gp_edge (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pinIn   (gpPin),
        .riseSel (gpPolPin),
        .pinEn   (gpIen_reg),
        .anyHit  (gpHit)
    );

    // ---------------------------------------------------------------
    // source collection, one bit per vector
    always_comb begin
        srcEvent                = '0;
        srcEvent[SRC_BUS_RESET] = usbBusReset;
        srcEvent[SRC_TAP_128US] = tap128;
        srcEvent[SRC_TAP_1MS]   = tap1ms;
        srcEvent[SRC_EP0]       = epDone[0];
        srcEvent[SRC_EP1]       = epDone[1];
        srcEvent[SRC_EP2]       = epDone[2];
        srcEvent[SRC_SINK]      = sinkHit;
        srcEvent[SRC_GPIO]      = gpHit;
    end

    // ---------------------------------------------------------------
    // configuration registers
    always_comb begin
        intMask_next = intMask_reg;
        sinkIen_next = sinkIen_reg;
        sinkPol_next = sinkPol_reg;
        gpIen_next   = gpIen_reg;
        gpPol_next   = gpPol_reg;
        if (regWr) begin
            if (isAddr(regAddr, OFS_INT_MASK)) begin
                intMask_next = regWrData[NUM_SRC-1:0];
            end
            if (isAddr(regAddr, OFS_SINK_IEN)) begin
                sinkIen_next = regWrData[SINK_W-1:0];
            end
            if (isAddr(regAddr, OFS_SINK_POL)) begin
                sinkPol_next = regWrData[SINK_W-1:0];
            end
            for (int p = 0; p < GP_PORTS; p++) begin
                if (isAddr(regAddr, OFS_GP_IEN0 + ADDR_W'(p))) begin
                    gpIen_next[p*GP_W +: GP_W] = regWrData[GP_W-1:0];
                end
            end
            if (isAddr(regAddr, OFS_GP_POL)) begin
                gpPol_next = regWrData[GP_PORTS-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            intMask_reg <= RST_MASK;
            sinkIen_reg <= RST_MASK;
            sinkPol_reg <= RST_POL;
            gpIen_reg   <= '0;
            gpPol_reg   <= '0;
        end else begin
            intMask_reg <= intMask_next;
            sinkIen_reg <= sinkIen_next;
            sinkPol_reg <= sinkPol_next;
            gpIen_reg   <= gpIen_next;
            gpPol_reg   <= gpPol_next;
        end
    end

    // ---------------------------------------------------------------
    // sticky status: write one to clear, or acknowledge of the presented vector
    // a masked source still records, so unmasking later shows old events
    always_comb begin
        clrBits = '0;
        if (regWr && isAddr(regAddr, OFS_INT_STAT)) begin
            clrBits = regWrData[NUM_SRC-1:0];
        end
        if (intAck && irq_reg) begin
            clrBits[vec_reg] = 1'b1;
        end
        // a new event in the clearing cycle survives
        status_next = (status_reg & ~clrBits) | srcEvent;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    // ---------------------------------------------------------------
    // priority selection and presentation
    assign active = status_reg & intMask_reg;

    vit_prio_enc #(
        .N (NUM_SRC)
    ) u_prio (
        .pend  (active),
        .valid (pickValid),
        .idx   (pickIdx)
    );

    always_comb begin
        irq_next = pickValid;
        vec_next = vec_reg;
        if (pickValid) begin
            vec_next = pickIdx;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
            vec_reg <= 3'h0;
        end else begin
            irq_reg <= irq_next;
            vec_reg <= vec_next;
        end
    end

    // ---------------------------------------------------------------
    // read path, data valid one cycle after the strobe
    always_comb begin
        rdData_next = 8'h00;
        if (regRd) begin
            case (regAddr)
                OFS_TMR_LO:   rdData_next = timer_reg[7:0];
                OFS_TMR_HI:   rdData_next = {4'h0, hiHold_reg};
                OFS_INT_STAT: rdData_next = status_reg;
                OFS_INT_MASK: rdData_next = intMask_reg;
                OFS_SINK_IEN: rdData_next = sinkIen_reg;
                OFS_SINK_POL: rdData_next = sinkPol_reg;
                OFS_GP_IEN0:  rdData_next = gpIen_reg[0*GP_W +: GP_W];
                OFS_GP_IEN1:  rdData_next = gpIen_reg[1*GP_W +: GP_W];
                OFS_GP_IEN2:  rdData_next = gpIen_reg[2*GP_W +: GP_W];
                OFS_GP_IEN3:  rdData_next = gpIen_reg[3*GP_W +: GP_W];
                OFS_GP_POL:   rdData_next = {4'h0, gpPol_reg};
                OFS_VECTOR: begin
                    rdData_next                = {5'h00, vec_reg};
                    rdData_next[VEC_VALID_BIT] = irq_reg;
                end
                default:      rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdData_reg <= 8'h00;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;
    assign irq       = irq_reg;
    assign irqVector = vec_reg;
endmodule // vit_irq_ctrl

/* hw/vit_pkg.sv */
// constants for the vectored interrupt controller with microsecond timer
package vit_pkg;
    // register bus geometry
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    // register offsets
    localparam logic [7:0]  OFS_TMR_LO    = 8'h00;
    localparam logic [7:0]  OFS_TMR_HI    = 8'h01;
    localparam logic [7:0]  OFS_INT_STAT  = 8'h02;
    localparam logic [7:0]  OFS_INT_MASK  = 8'h03;
    localparam logic [7:0]  OFS_SINK_IEN  = 8'h04;
    localparam logic [7:0]  OFS_SINK_POL  = 8'h05;
    localparam logic [7:0]  OFS_GP_IEN0   = 8'h06;
    localparam logic [7:0]  OFS_GP_IEN1   = 8'h07;
    localparam logic [7:0]  OFS_GP_IEN2   = 8'h08;
    localparam logic [7:0]  OFS_GP_IEN3   = 8'h09;
    localparam logic [7:0]  OFS_GP_POL    = 8'h0a;
    localparam logic [7:0]  OFS_VECTOR    = 8'h0b;
    // reset values
    localparam logic [7:0]  RST_MASK      = 8'h00;
    localparam logic [7:0]  RST_POL       = 8'h00;
    localparam logic [11:0] RST_TIMER     = 12'h000;
    // interrupt source positions, also their vector numbers
    localparam int          SRC_BUS_RESET = 0;
    localparam int          SRC_TAP_128US = 1;
    localparam int          SRC_TAP_1MS   = 2;
    localparam int          SRC_EP0       = 3;
    localparam int          SRC_EP1       = 4;
    localparam int          SRC_EP2       = 5;
    localparam int          SRC_SINK      = 6;
    localparam int          SRC_GPIO      = 7;
    localparam int          NUM_SRC       = 8;
    // timer geometry and taps
    localparam int          TIMER_W       = 12;
    localparam int          TAP_128US_BIT = 7;
    localparam int          TAP_1MS_BIT   = 10;
    // tick derived from clock rate
    localparam int          CLK_HZ        = 200_000_000;
    localparam int          TICK_HZ       = 1_000_000;
    localparam int          TICK_CYCLES   = CLK_HZ / TICK_HZ;
    localparam logic [7:0]  TICK_LAST     = 8'(TICK_CYCLES - 1);
    // vector register: bit 7 tells a request is present
    localparam int          VEC_VALID_BIT = 7;
endpackage

/* hw/vit_prio_enc.sv */
// fixed-priority picker, lowest index wins
`timescale 1ns/1ps
module vit_prio_enc
    import vit_pkg::*;
#(
    parameter int N = 8
) (
    // pending requests
    input  wire logic [N-1:0]         pend,
    // choice
    output      logic                 valid,
    output      logic [$clog2(N)-1:0] idx
);
    always_comb begin
        valid = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                valid = 1'b1;
                idx   = ($clog2(N))'(i);
            end
        end
    end
endmodule // vit_prio_enc

/* test/tb_vit_irq_ctrl.sv */
// self-checking testbench for the vectored interrupt controller
`timescale 1ns/1ps
module tb_vit_irq_ctrl
    import vit_pkg::*;
;
    localparam logic [7:0]  PS[12] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [31:0] PG[12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h80000000, 32'h0,
                                       32'h2, 32'h0};
    localparam logic [7:0]  PX[12] = '{8'h40, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [7:0]  regWrData = 8'h00;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [7:0]  regRdData;
    logic        usbBusReset = 1'b0;
    logic [2:0]  epDone = 3'h0;
    logic [7:0]  sinkPin = 8'h00;
    logic [31:0] gpPin = 32'h0;
    logic        srvEn = 1'b0;
    logic [3:0]  ackDelay = 4'h0;
    logic        intAck, irq;
    logic [2:0]  irqVector;
    logic [7:0]  d, e;
    logic [11:0] t0, t1;
    int          miscompares = 0;
    int          compares = 0;
    int          acks[8] = '{default: 0};
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    vit_irq_ctrl i_vit_irq_ctrl (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .usbBusReset(usbBusReset), .epDone(epDone),
        .sinkPin(sinkPin), .gpPin(gpPin), .intAck(intAck), .irq(irq), .irqVector(irqVector));
    vit_cpu_model i_vit_cpu_model (.clk_sys(clk_sys), .nrst(nrst), .srvEn(srvEn), .ackDelay(ackDelay),
        .irq(irq), .intAck(intAck));
    always @(posedge clk_sys) if (intAck === 1'b1 && irq === 1'b1) acks[irqVector]++;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // two reads back to back, the second with no gap
    task automatic rd2(input logic [7:0] a, input logic [7:0] b, output logic [7:0] v0, output logic [7:0] v1);
        @(posedge clk_sys);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regAddr <= b;
        #1 v0 = regRdData;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v1 = regRdData;
    endtask
    task automatic ev(input logic b, input logic [2:0] ep);
        @(posedge clk_sys);
        usbBusReset <= b;
        epDone      <= ep;
        @(posedge clk_sys);
        usbBusReset <= 1'b0;
        epDone      <= 3'h0;
    endtask
    // pins pass a two-flop sync, so allow six cycles before looking
    task automatic pin(input logic [7:0] s, input logic [31:0] g, input logic [7:0] ex);
        @(posedge clk_sys);
        sinkPin <= s;
        gpPin   <= g;
        repeat (6) @(posedge clk_sys);
        rd2(OFS_INT_STAT, OFS_VECTOR, d, e);
        chk(d & 8'hc0, ex);
        if (ex != 8'h00) chk(e, {1'b1, 4'h0, ex[7] ? 3'(SRC_GPIO) : 3'(SRC_SINK)});
        wr(OFS_INT_STAT, 8'hc0);
    endtask
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge clk_sys);
        miscompares++;
        $display("CHECK FAILED at %0t: run too long", $time);
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int a = 2; a < 14; a++) begin
            rd2(8'(a), 8'hff, d, e);
            chk(d, 8'h00);
        end
        wr(OFS_VECTOR, 8'hff);
        wr(OFS_INT_MASK, 8'ha5);
        rd2(OFS_VECTOR, OFS_INT_MASK, d, e);
        chk(d, 8'h00);
        chk(e, 8'ha5);
        // timer: one low-byte wrap, prompt acks of the 128 us tap
        wr(OFS_INT_MASK, 8'h02);
        srvEn <= 1'b1;
        rd2(OFS_TMR_LO, OFS_TMR_HI, d, e);
        t0 = {e[3:0], d};
        repeat ((258 - int'(d)) * TICK_CYCLES) @(posedge clk_sys);
        rd2(OFS_TMR_HI, OFS_TMR_HI, d, e);
        chk(d, {4'h0, t0[11:8]});
        rd2(OFS_TMR_LO, OFS_TMR_LO, d, e);
        rd2(OFS_TMR_LO, OFS_TMR_HI, d, e);
        t1 = {e[3:0], d};
        chk(e, {4'h0, t0[11:8] + 4'h1});
        d = 8'(t1 - t0 - 12'(258 - int'(t0[7:0])));
        chk({7'h0, d > 8'h01}, 8'h00);
        chk(8'(acks[SRC_TAP_128US]), 8'h01);
        rd2(OFS_INT_STAT, OFS_INT_STAT, d, e);
        chk(d & 8'h06, 8'h00);
        srvEn <= 1'b0;
        // all usb events at once, drained by priority
        wr(OFS_INT_MASK, 8'hf9);
        ev(1'b1, 3'h7);
        for (int i = 0; i < 6; i++) begin
            if (i == 0 || i > 2) begin
                rd2(OFS_VECTOR, OFS_INT_STAT, d, e);
                chk(d, 8'h80 | 8'(i));
                chk(e & 8'hf9, 8'h39 & ~8'((1 << i) - 1));
                wr(OFS_INT_STAT, 8'(1 << i));
            end
        end
        wr(OFS_INT_MASK, 8'h00);
        ev(1'b0, 3'h2);
        rd2(OFS_INT_STAT, OFS_VECTOR, d, e);
        chk(d & 8'h39, 8'h10);
        chk(e & 8'h80, 8'h00);
        wr(OFS_INT_STAT, 8'h10);
        // slow processor acknowledge
        wr(OFS_INT_MASK, 8'h08);
        ackDelay <= 4'h5;
        srvEn    <= 1'b1;
        ev(1'b0, 3'h1);
        repeat (15) @(posedge clk_sys);
        chk(8'(acks[SRC_EP0]), 8'h01);
        rd2(OFS_INT_STAT, OFS_VECTOR, d, e);
        chk(d & 8'h08, 8'h00);
        srvEn <= 1'b0;
        // port pins: enables and polarities
        wr(OFS_INT_MASK, 8'hc0);
        wr(OFS_SINK_IEN, 8'h03);
        wr(OFS_SINK_POL, 8'h01);
        wr(OFS_GP_IEN0, 8'h01);
        wr(OFS_GP_IEN3, 8'h80);
        wr(OFS_GP_POL, 8'h01);
        for (int i = 0; i < 12; i++) pin(PS[i], PG[i], PX[i]);
        // second reset in mid-run
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        rd2(OFS_SINK_IEN, OFS_GP_POL, d, e);
        chk(d, RST_MASK);
        chk(e, RST_POL);
        close_out();
    end
endmodule // tb_vit_irq_ctrl

/* test/vit_cpu_model.sv */
// processor core model that acknowledges presented interrupt vectors
`timescale 1ns/1ps
module vit_cpu_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // service control
    input  wire logic       srvEn,
    input  wire logic [3:0] ackDelay,
    // controller side
    input  wire logic       irq,
    output      logic       intAck
);
    logic [3:0] wait_reg;
    logic [1:0] cool_reg;
    // cool-down lets irq fall before the next look, else one event is acked twice
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            intAck   <= 1'b0;
            wait_reg <= 4'h0;
            cool_reg <= 2'h0;
        end else begin
            intAck <= 1'b0;
            if (cool_reg != 2'h0)
                cool_reg <= cool_reg - 2'h1;
            else if (srvEn && irq && !intAck) begin
                if (wait_reg == ackDelay) begin
                    intAck   <= 1'b1;
                    wait_reg <= 4'h0;
                    cool_reg <= 2'h3;
                end else
                    wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule // vit_cpu_model

/* test/vit_irq_chk.sv */
// assertion checker for the vectored interrupt controller
`timescale 1ns/1ps
module vit_irq_chk
    import vit_pkg::*;
(
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              nrst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic              regWr,
    input wire logic              regRd,
    input wire logic [DATA_W-1:0] regRdData,
    // events and processor side
    input wire logic              usbBusReset,
    input wire logic [2:0]        epDone,
    input wire logic              intAck,
    input wire logic              irq,
    input wire logic [2:0]        irqVector
);
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // shadow of the mask so enable conditions need no internal probe
    always_comb mask_next = (regWr && regAddr == OFS_INT_MASK) ? regWrData : mask_reg;
    always_ff @(posedge clk_sys or negedge nrst)
        if (!nrst) mask_reg <= RST_MASK;
        else mask_reg <= mask_next;
    a_idle_data_zero: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data not zero outside a read");
    a_hi_upper_zero: assert property (regRd && regAddr == OFS_TMR_HI |=> regRdData[7:4] == 4'h0)
        else $error("timer high read has upper bits set");
    a_hi_latch_hold: assert property (regRd && regAddr == OFS_TMR_HI ##1 regRd && regAddr == OFS_TMR_HI
        |=> $stable(regRdData)) else $error("held nibble changed without low read");
    a_lo_step_one: assert property (regRd && regAddr == OFS_TMR_LO ##1 regRd && regAddr == OFS_TMR_LO
        |=> 8'(regRdData - $past(regRdData)) <= 8'h01) else $error("timer low byte jumped");
    a_vec_read_back: assert property (regRd && regAddr == OFS_VECTOR
        |=> regRdData == {$past(irq), 4'h0, $past(irqVector)}) else $error("vector read mismatch");
    a_unmapped_zero: assert property (regRd && regAddr > OFS_VECTOR |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_ep_raises_irq: assert property (epDone[0] && !regWr && mask_reg[SRC_EP0]
        ##1 !regWr && !intAck |=> irq) else $error("endpoint event raised no request");
    a_bus_reset_first: assert property (usbBusReset && !regWr && mask_reg[SRC_BUS_RESET]
        ##1 !regWr && !intAck |=> irq && irqVector == 3'(SRC_BUS_RESET)) else $error("bus reset not first");
    a_irq_fall_cause: assert property ($fell(irq)
        |-> $past(intAck, 2) || $past(regWr, 2) || $past(regWr)) else $error("request dropped by itself");
endmodule // vit_irq_chk
bind vit_irq_ctrl vit_irq_chk i_vit_irq_chk (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .usbBusReset(usbBusReset), .epDone(epDone),
    .intAck(intAck), .irq(irq), .irqVector(irqVector));
